// >>> hw/cmd_decode.v
// Purpose: command, address and control input decoder of a memory module
// Assumes: pins arrive from the host asynchronously, sampled on aclk
// Notes: decoded command leaves as a one-cycle pulse with fields registered
`timescale 1ns/100ps
`default_nettype none
`include "cmd_decode_defs.vh"
module cdd_cmd_decode (
    input wire aclk,
    input wire aresetn,
    input wire clk_en,
    // memory pins
    input wire rank_sel_n,
    input wire [2:0] chip_id,
    input wire act_n,
    input wire ras_n_a16,
    input wire cas_n_a15,
    input wire we_n_a14,
    input wire [1:0] bank_group,
    input wire [1:0] bank_addr,
    input wire [13:0] addr_lo,
    input wire addr_a17,
    input wire term_ctl,
    input wire mem_cke,
    input wire mem_reset_n,
    input wire thermal_event,
    input wire burst_done,
    // decoded outputs
    output reg cmd_valid,
    output reg [3:0] cmd_code,
    output reg [2:0] cmd_die,
    output reg [1:0] cmd_bg,
    output reg [1:0] cmd_ba,
    output reg [17:0] cmd_addr,
    output reg cmd_auto_pre,
    output reg cmd_chop,
    output reg [3:0] mrs_select,
    output reg nominal_termination_value,
    output reg crc_append,
    output reg vref_monitor,
    output reg event_n,
    output reg [1:0] power_state,
    // axi4-lite slave
    input wire [3:0] s_awaddr,
    input wire s_awvalid,
    output wire s_awready,
    input wire [31:0] s_wdata,
    input wire [3:0] s_wstrb,
    input wire s_wvalid,
    output wire s_wready,
    output reg [1:0] s_bresp,
    output reg s_bvalid,
    input wire s_bready,
    input wire [3:0] s_araddr,
    input wire s_arvalid,
    output wire s_arready,
    output reg [31:0] s_rdata,
    output reg [1:0] s_rresp,
    output reg s_rvalid,
    input wire s_rready
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // packed pin word, one bit per synchronised input except rank select and chip id
    localparam W = 32;
    wire [W-1:0] pin_raw;
    reg [W-1:0] pin_s1_q;
    reg [W-1:0] pin_s2_q;
    // four spare bits pad the word to its full width
    assign pin_raw = {4'h0, burst_done, thermal_event, mem_reset_n, mem_cke, term_ctl, addr_a17,
                      addr_lo, bank_addr, bank_group, we_n_a14, cas_n_a15, ras_n_a16, act_n};
    // two flops per pin, sampled on the rising edge
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_q <= 32'h00000000;
            pin_s2_q <= 32'h00000000;
        end else if (clk_en) begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end
    // rank select and chip id, separate for clarity
    reg rank_s1_q, rank_s2_q;
    reg [2:0] cid_s1_q, cid_s2_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            rank_s1_q <= 1'b1;
            rank_s2_q <= 1'b1;
            cid_s1_q <= 3'h0;
            cid_s2_q <= 3'h0;
        end else if (clk_en) begin
            rank_s1_q <= rank_sel_n;
            rank_s2_q <= rank_s1_q;
            cid_s1_q <= chip_id;
            cid_s2_q <= cid_s1_q;
        end
    end
    // second stage taps, the only readers of the pin word
    wire s_act_n = pin_s2_q[0];
    wire s_ras = pin_s2_q[1];
    wire s_cas = pin_s2_q[2];
    wire s_we = pin_s2_q[3];
    wire [1:0] s_bg = pin_s2_q[5:4];
    wire [1:0] s_ba = pin_s2_q[7:6];
    wire [13:0] s_alo = pin_s2_q[21:8];
    wire s_a17 = pin_s2_q[22];
    wire s_term = pin_s2_q[23];
    wire s_cke = pin_s2_q[24];
    wire s_mrst_n = pin_s2_q[25];
    wire s_therm = pin_s2_q[26];
    wire s_bdone = pin_s2_q[27];
    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0] ctrl_q; // term, crc, vref, a17, stack
    reg [3:0] last_cmd_q; // last decoded command
    reg [17:0] last_addr_q; // last address
    reg [15:0] open_rows_q; // one bit per bank
    // ----------------------------------------
    // command truth table
    // ----------------------------------------
    // ras, cas, we pattern under a high activate strobe
    function [3:0] decode_cmd;
        input an, ras, cas, we, cke_prev, cke_now;
        begin
            if (!an)
                decode_cmd = `CDD_CMD_ACT;
            else begin
                case ({ras, cas, we})
                    // refresh with clock enable falling enters self refresh
                    3'b001: decode_cmd = (cke_prev && !cke_now) ? `CDD_CMD_SRE : `CDD_CMD_REF;
                    3'b000: decode_cmd = `CDD_CMD_MRS;
                    3'b101: decode_cmd = `CDD_CMD_RD;
                    3'b100: decode_cmd = `CDD_CMD_WR;
                    3'b010: decode_cmd = `CDD_CMD_PRE;
                    3'b110: decode_cmd = `CDD_CMD_ZQ;
                    default: decode_cmd = `CDD_CMD_NOP;
                endcase
            end
        end
    endfunction
    // die count allowed by the stack setting
    function die_ok;
        input [1:0] stack;
        input [2:0] die;
        begin
            case (stack)
                2'h0: die_ok = 1'b1;
                2'h1: die_ok = (die[2:1] == 2'h0);
                2'h2: die_ok = (die[2] == 1'b0);
                default: die_ok = 1'b1;
            endcase
        end
    endfunction
    // ----------------------------------------
    // power state machine
    // ----------------------------------------
    reg cke_prev_q;
    reg [1:0] ps_q, ps_d;
    wire [3:0] raw_cmd = decode_cmd(s_act_n, s_ras, s_cas, s_we, cke_prev_q, s_cke);
    // rank and die must both pick this module
    wire sel_ok = !rank_s2_q && die_ok(ctrl_q[5:4], cid_s2_q);
    wire in_sr = (ps_q == `CDD_PS_SR);
    wire in_pd = (ps_q == `CDD_PS_PPD) || (ps_q == `CDD_PS_APD);
    // buffers off in power states gate the command inputs
    wire cmd_take = sel_ok && (ps_q == `CDD_PS_ACTIVE) && s_cke;
    wire sre_take = sel_ok && (ps_q == `CDD_PS_ACTIVE) && (raw_cmd == `CDD_CMD_SRE);
    // next power state
    always @* begin
        ps_d = ps_q;
        case (ps_q)
            `CDD_PS_ACTIVE: begin
                if (sre_take)
                    ps_d = `CDD_PS_SR;
                // idle banks give precharge power-down, open rows active
                else if (cke_prev_q && !s_cke)
                    ps_d = (open_rows_q == 16'h0000) ? `CDD_PS_PPD : `CDD_PS_APD;
            end
            `CDD_PS_PPD, `CDD_PS_APD: begin
                // any high clock enable leaves power-down
                if (s_cke)
                    ps_d = `CDD_PS_ACTIVE;
            end
            `CDD_PS_SR: begin
                // exit wants a fresh rise, not a held high level
                if (s_cke && !cke_prev_q)
                    ps_d = `CDD_PS_ACTIVE;
            end
            default: ps_d = `CDD_PS_ACTIVE;
        endcase
    end
    // state, bank bookkeeping and decoded outputs
    // the module reset pin clears decoder state, not the control register
    wire full_rst = !aresetn || !s_mrst_n;
    wire [3:0] bank_idx = {s_bg, s_ba};
    always @(posedge aclk) begin
        if (full_rst) begin
            ps_q <= `CDD_PS_ACTIVE;
            cke_prev_q <= 1'b0;
            open_rows_q <= 16'h0000;
            cmd_valid <= 1'b0;
            cmd_code <= `CDD_CMD_NOP;
            cmd_die <= 3'h0;
            cmd_bg <= 2'h0;
            cmd_ba <= 2'h0;
            cmd_addr <= 18'h00000;
            cmd_auto_pre <= 1'b0;
            cmd_chop <= 1'b0;
            mrs_select <= 4'h0;
            last_cmd_q <= `CDD_CMD_NOP;
            last_addr_q <= 18'h00000;
        end else if (clk_en) begin
            ps_q <= ps_d;
            cke_prev_q <= s_cke;
            cmd_valid <= cmd_take && (raw_cmd != `CDD_CMD_NOP);
            if (cmd_take && (raw_cmd != `CDD_CMD_NOP)) begin
                // precharge with the all-banks bit reports as prea
                cmd_code <= (raw_cmd == `CDD_CMD_PRE && s_alo[10]) ? `CDD_CMD_PREA : raw_cmd;
                cmd_die <= cid_s2_q;
                cmd_bg <= s_bg;
                cmd_ba <= s_ba;
                // row keeps a16..a14 only on activate
                cmd_addr <= {(ctrl_q[`CDD_CTRL_A17_VALID] & s_a17),
                             (raw_cmd == `CDD_CMD_ACT) ? {s_ras, s_cas, s_we} : 3'h0, s_alo};
                // auto precharge and chop mean something only on accesses
                cmd_auto_pre <= (raw_cmd == `CDD_CMD_RD || raw_cmd == `CDD_CMD_WR) && s_alo[10];
                cmd_chop <= (raw_cmd == `CDD_CMD_RD || raw_cmd == `CDD_CMD_WR) && !s_alo[12];
                // mode register select reads zero for other commands
                mrs_select <= {s_bg[0], 1'b0, s_ba} & {4{raw_cmd == `CDD_CMD_MRS}};
                last_cmd_q <= raw_cmd;
                last_addr_q <= {s_a17, s_ras, s_cas, s_we, s_alo};
                // track open rows for power-down choice
                case (raw_cmd)
                    `CDD_CMD_ACT: open_rows_q <= open_rows_q | (16'h0001 << bank_idx);
                    `CDD_CMD_PRE: open_rows_q <= s_alo[10] ? 16'h0000 : (open_rows_q & ~(16'h0001 << bank_idx));
                    `CDD_CMD_RD, `CDD_CMD_WR: begin
                        if (s_alo[10])
                            open_rows_q <= open_rows_q & ~(16'h0001 << bank_idx);
                    end
                    default: open_rows_q <= open_rows_q;
                endcase
            end
        end
    end
    // ----------------------------------------
    // termination, crc, reference, thermal
    // ----------------------------------------
    always @(posedge aclk) begin
        if (full_rst) begin
            nominal_termination_value <= 1'b0;
            crc_append <= 1'b0;
            vref_monitor <= 1'b0;
            event_n <= 1'b1;
        end else if (clk_en) begin
            // termination stays live in power-down, off in self refresh
            nominal_termination_value <= s_term && ctrl_q[`CDD_CTRL_TERM_EN] && !in_sr;
            crc_append <= ctrl_q[`CDD_CTRL_CRC_EN] && s_bdone;
            vref_monitor <= ctrl_q[`CDD_CTRL_VREF_MON];
            event_n <= !s_therm;
        end
    end
    // reported state lags the internal one by a cycle
    always @(posedge aclk) begin
        if (full_rst)
            power_state <= `CDD_PS_ACTIVE;
        else if (clk_en)
            power_state <= ps_q;
    end
    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    reg aw_q, w_q;
    reg [3:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    // write ready drops while a write is held or answered, read ready while a read is answered
    assign s_awready = !aw_q && !s_bvalid;
    assign s_wready = !w_q && !s_bvalid;
    assign s_arready = !s_rvalid;
    // write path: address and data in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= 2'h0;
            ctrl_q <= `CDD_CTRL_RESET;
        end else if (clk_en) begin
            if (s_awvalid && s_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_wdata;
                wstrb_q <= s_wstrb;
            end
            if (aw_q && w_q) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_bvalid <= 1'b1;
                // unmapped writes answer slverr and change nothing
                if (awaddr_q == `CDD_REG_CTRL) begin
                    s_bresp <= 2'h0;
                    if (wstrb_q[0])
                        ctrl_q <= wdata_q[7:0];
                end else
                    s_bresp <= 2'h2;
            end else if (s_bvalid && s_bready)
                s_bvalid <= 1'b0;
        end
    end
    // read path
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata <= 32'h00000000;
            s_rresp <= 2'h0;
        end else if (clk_en) begin
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rresp <= 2'h0;
                // status gathers open rows, clock enable and state
                case (s_araddr)
                    `CDD_REG_CTRL: s_rdata <= {24'h000000, ctrl_q};
                    `CDD_REG_STATUS: s_rdata <= {open_rows_q, 12'h000, s_cke, in_pd, ps_q};
                    `CDD_REG_CMD: s_rdata <= {28'h0000000, last_cmd_q};
                    `CDD_REG_ADDR: s_rdata <= {14'h0000, last_addr_q};
                    // unmapped reads return zero with slverr
                    default: begin
                        s_rdata <= 32'h00000000;
                        s_rresp <= 2'h2;
                    end
                endcase
            end else if (s_rvalid && s_rready)
                s_rvalid <= 1'b0;
        end
    end
endmodule // cdd_cmd_decode
`default_nettype wire

// >>> hw/cmd_decode_defs.vh
// Purpose: constants for the module command input decoder
// Assumes: included by hw/cmd_decode.v and by the bench checker and testbench
// Notes: register offsets are byte addresses on the axi4-lite slave
// Contract
// - capture inputs on rising true clock
// - rank select high masks the command
// - chip id selects stack die
// - termination input enables nominal termination
// - termination ignored when mode register one disables
// - activate low: pins are row a16..a14
// - activate high: pins encode other commands
// - bank group selects group, mrs register
// - bank address selects bank, mrs register
// - address gives row, column or opcode
// - a17 valid only for 16gb x4
// - a10 high on access: auto precharge
// - a10 on precharge: one or all
// - a12 low on access: burst chopped
// - reset low resets; controller keeps high
// - clock enable low gives power states
// - power states gate input buffers
// - self refresh exit sampled synchronously
// - crc appended when enabled
// - mode register four a4 shows reference
// - thermal event drives active-low output
`ifndef CMD_DECODE_DEFS_VH
`define CMD_DECODE_DEFS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CDD_REG_CTRL 4'h0
`define CDD_REG_STATUS 4'h4
`define CDD_REG_CMD 4'h8
`define CDD_REG_ADDR 4'hc
// ----------------------------------------
// control fields
// ----------------------------------------
`define CDD_CTRL_TERM_EN 0
`define CDD_CTRL_CRC_EN 1
`define CDD_CTRL_VREF_MON 2
`define CDD_CTRL_A17_VALID 3
`define CDD_CTRL_STACK_LO 4
`define CDD_CTRL_STACK_HI 5
`define CDD_CTRL_RESET 8'h01
// ----------------------------------------
// decoded command codes
// ----------------------------------------
`define CDD_CMD_NOP 4'h0
`define CDD_CMD_ACT 4'h1
`define CDD_CMD_RD 4'h2
`define CDD_CMD_WR 4'h3
`define CDD_CMD_PRE 4'h4
`define CDD_CMD_PREA 4'h5
`define CDD_CMD_REF 4'h6
`define CDD_CMD_MRS 4'h7
`define CDD_CMD_SRE 4'h8
`define CDD_CMD_ZQ 4'h9
// ----------------------------------------
// power states
// ----------------------------------------
`define CDD_PS_ACTIVE 2'h0
`define CDD_PS_PPD 2'h1
`define CDD_PS_APD 2'h2
`define CDD_PS_SR 2'h3
`endif

// >>> bench/cdd_host_model.sv
// Purpose: host controller model driving the module command pins
// Assumes: one command per call, launched after a rising edge
// Notes: deselected lines show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none
module cdd_host_model (
    input wire logic aclk,
    output logic rank_sel_n,
    output logic [2:0] chip_id,
    output logic act_n,
    output logic ras_n_a16,
    output logic cas_n_a15,
    output logic we_n_a14,
    output logic [1:0] bank_group,
    output logic [1:0] bank_addr,
    output logic [13:0] addr_lo,
    output logic addr_a17,
    output logic mem_cke,
    output logic mem_reset_n
);
    // ------------------------------------
    // idle pins, module reset held high
    // ------------------------------------
    initial begin
        // no mask or inversion lines are modelled
        {rank_sel_n, act_n, ras_n_a16, cas_n_a15, we_n_a14, mem_cke, mem_reset_n} = 7'h7f;
        {chip_id, bank_group, bank_addr, addr_lo, addr_a17} = 22'h0;
    end
    // one command cycle, then the bus is released
    task automatic send(input logic cs, act, input logic [2:0] c, input logic [13:0] a, input logic a17, cke);
        @(posedge aclk);
        {rank_sel_n, act_n, ras_n_a16, cas_n_a15, we_n_a14} <= {cs, act, c};
        {bank_group, bank_addr, addr_lo, addr_a17} <= {2'h1, 2'h2, a, a17};
        mem_cke <= cke;
        @(posedge aclk);
        // released lines must not keep the last value
        {rank_sel_n, act_n, ras_n_a16, cas_n_a15, we_n_a14} <= {1'b1, ~act, ~c};
        {bank_group, bank_addr, addr_lo, addr_a17} <= {2'h2, 2'h1, ~a, ~a17};
    endtask
    // die id for stacked parts, held until changed
    task automatic set_die(input logic [2:0] d);
        @(posedge aclk);
        chip_id <= d;
    endtask
endmodule // cdd_host_model
`default_nettype wire

// >>> bench/cdd_cmd_decode_chk.sv
// Purpose: port checker of the command input decoder
// Assumes: pin latency of three edges to the decoded pulse
// Notes: bound to every decoder instance
`timescale 1ns/100ps
`default_nettype none
`include "cmd_decode_defs.vh"
module cdd_cmd_decode_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic rank_sel_n,
    input wire logic act_n,
    input wire logic ras_n_a16,
    input wire logic cas_n_a15,
    input wire logic we_n_a14,
    input wire logic [13:0] addr_lo,
    input wire logic term_ctl,
    input wire logic mem_cke,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_code,
    input wire logic [17:0] cmd_addr,
    input wire logic cmd_auto_pre,
    input wire logic cmd_chop,
    input wire logic nominal_termination_value,
    input wire logic [1:0] power_state,
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic s_bvalid,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire logic [31:0] s_rdata
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------
    // command pin sequences
    // ------------------------------------
    wire logic live;
    assign live = !rank_sel_n && mem_cke && clk_en && power_state == `CDD_PS_ACTIVE;
    sequence s_act_pin; live && !act_n; endsequence
    sequence s_rd_pin; live && act_n && {ras_n_a16, cas_n_a15, we_n_a14} == 3'b101; endsequence
    sequence s_wr_taken; s_awvalid && s_awready && s_wvalid && s_wready; endsequence
    chk_act_decode: assert property (s_act_pin |-> ##3 cmd_valid && cmd_code == `CDD_CMD_ACT &&
        cmd_addr[16:0] == {$past(ras_n_a16, 3), $past(cas_n_a15, 3), $past(we_n_a14, 3), $past(addr_lo, 3)})
        else $error("activate decoded wrongly");
    chk_read_decode: assert property (s_rd_pin |-> ##3 cmd_valid && cmd_code == `CDD_CMD_RD &&
        cmd_auto_pre == $past(addr_lo[10], 3) && cmd_chop == !$past(addr_lo[12], 3))
        else $error("read decoded wrongly");
    chk_rank_mask: assert property (rank_sel_n && clk_en |-> ##3 !cmd_valid)
        else $error("deselected command decoded");
    chk_term_off: assert property (!term_ctl [*4] |-> !nominal_termination_value)
        else $error("termination without control input");
    chk_pd_entry: assert property (!mem_cke [*5] |-> power_state != `CDD_PS_ACTIVE)
        else $error("no power state with enable low");
    // ------------------------------------
    // register bus
    // ------------------------------------
    chk_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read answer late");
    chk_write_answer: assert property (s_wr_taken |-> ##2 s_bvalid)
        else $error("write answer late");
    chk_read_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read answer not held");
    chk_reset_values: assert property (disable iff (1'b0) !aresetn |=> !cmd_valid && !s_bvalid && !s_rvalid)
        else $error("outputs not cleared by reset");
endmodule // cdd_cmd_decode_chk
bind cdd_cmd_decode cdd_cmd_decode_chk u_chk (.aclk, .aresetn, .clk_en, .rank_sel_n, .act_n, .ras_n_a16,
    .cas_n_a15, .we_n_a14, .addr_lo, .term_ctl, .mem_cke, .cmd_valid, .cmd_code, .cmd_addr, .cmd_auto_pre,
    .cmd_chop, .nominal_termination_value, .power_state, .s_awvalid, .s_awready, .s_wvalid, .s_wready,
    .s_bvalid, .s_arvalid, .s_arready, .s_rvalid, .s_rready, .s_rdata);
`default_nettype wire

// >>> bench/ddr4_module_command_input_decode_tb.sv
// Purpose: self-checking bench of the command input decoder
// Assumes: host model drives the pins, bench drives axi4-lite
// Notes: expected codes come from the command table below
`timescale 1ns/100ps
`default_nettype none
`include "cmd_decode_defs.vh"
module ddr4_module_command_input_decode_tb;
    logic aclk, aresetn, clk_en, term_ctl, thermal_event, burst_done, seen;
    logic rank_sel_n, act_n, ras_n_a16, cas_n_a15, we_n_a14, addr_a17, mem_cke, mem_reset_n;
    logic [2:0] chip_id, cmd_die;
    logic [1:0] bank_group, bank_addr, power_state, s_bresp, s_rresp, cmd_bg, cmd_ba;
    logic [13:0] addr_lo;
    logic cmd_valid, cmd_auto_pre, cmd_chop, nominal_termination_value, crc_append, vref_monitor, event_n;
    logic [3:0] cmd_code, mrs_select, s_awaddr, s_araddr, s_wstrb;
    logic [17:0] cmd_addr;
    logic [31:0] s_wdata, s_rdata, d;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
    integer miscompares = 0, n_tests = 0, i, j;
    cdd_host_model hm (.aclk, .rank_sel_n, .chip_id, .act_n, .ras_n_a16, .cas_n_a15, .we_n_a14,
        .bank_group, .bank_addr, .addr_lo, .addr_a17, .mem_cke, .mem_reset_n);
    cdd_cmd_decode dut (.aclk, .aresetn, .clk_en, .rank_sel_n, .chip_id, .act_n, .ras_n_a16, .cas_n_a15,
        .we_n_a14, .bank_group, .bank_addr, .addr_lo, .addr_a17, .term_ctl, .mem_cke, .mem_reset_n,
        .thermal_event, .burst_done, .cmd_valid, .cmd_code, .cmd_die, .cmd_bg, .cmd_ba, .cmd_addr,
        .cmd_auto_pre, .cmd_chop, .mrs_select, .nominal_termination_value, .crc_append, .vref_monitor,
        .event_n, .power_state, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
        .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
        .s_rready);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // ------------------------------------
    // compare, verdict, bus tasks
    // ------------------------------------
    task automatic check(input logic [31:0] got, exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic hang(input integer k);
        if (k >= 40) begin
            miscompares = miscompares + 1;
            give_verdict;
        end
    endtask
    // address and data offered together, each released when taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
        logic ta, tw, left;
        integer k;
        @(posedge aclk);
        {s_awaddr, s_wdata, s_awvalid, s_wvalid, s_bready} <= {a, v, 3'h7};
        k = 0;
        do begin
            @(negedge aclk);
            ta = s_awvalid && s_awready;
            tw = s_wvalid && s_wready;
            left = (s_awvalid && !ta) || (s_wvalid && !tw);
            @(posedge aclk);
            if (ta) s_awvalid <= 1'b0;
            if (tw) s_wvalid <= 1'b0;
            k = k + 1;
        end while (left && k < 40);
        hang(k);
        k = 0;
        while (s_bvalid !== 1'b1 && k < 40) begin
            @(negedge aclk);
            k = k + 1;
        end
        hang(k);
        check(s_bresp, 2'h0);
        @(posedge aclk);
        s_bready <= 1'b0;
    endtask
    // ready raised a cycle late so the answer must wait
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] v);
        logic t;
        integer k;
        @(posedge aclk);
        {s_araddr, s_arvalid} <= {a, 1'b1};
        k = 0;
        do begin
            @(negedge aclk);
            t = s_arready;
            @(posedge aclk);
            if (t) s_arvalid <= 1'b0;
            k = k + 1;
        end while (!t && k < 40);
        hang(k);
        @(posedge aclk);
        s_rready <= 1'b1;
        k = 0;
        do begin
            @(negedge aclk);
            k = k + 1;
        end while (s_rvalid !== 1'b1 && k < 40);
        hang(k);
        v = s_rdata;
        check(s_rresp, 2'h0);
        @(posedge aclk);
        s_rready <= 1'b0;
    endtask
    // one pin command, then watch for the decoded pulse
    task automatic run(input logic cs, act, input logic [2:0] c, input logic [13:0] a, input logic a17, cke);
        hm.send(cs, act, c, a, a17, cke);
        seen = 1'b0;
        repeat (8) begin
            @(negedge aclk);
            if (cmd_valid === 1'b1) seen = 1'b1;
        end
    endtask
    function automatic logic [3:0] exp_code(input logic [2:0] c, input logic a10);
        case (c)
            3'b000: exp_code = `CDD_CMD_MRS;
            3'b001: exp_code = `CDD_CMD_REF;
            3'b010: exp_code = a10 ? `CDD_CMD_PREA : `CDD_CMD_PRE;
            3'b100: exp_code = `CDD_CMD_WR;
            3'b101: exp_code = `CDD_CMD_RD;
            3'b110: exp_code = `CDD_CMD_ZQ;
            default: exp_code = `CDD_CMD_NOP;
        endcase
    endfunction
    // ------------------------------------
    // main sequence
    // ------------------------------------
    initial begin
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, term_ctl, thermal_event, burst_done, aresetn} = 9'h0;
        {s_awaddr, s_araddr, s_wdata, s_wstrb, clk_en} = 45'h1f;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        check({event_n, power_state}, {1'b1, `CDD_PS_ACTIVE});
        axi_rd(`CDD_REG_CTRL, d);
        check(d, `CDD_CTRL_RESET);
        for (i = 0; i < 2; i++) begin
            run(0, 0, 3'b101, 14'h2a5c, 1, 1);
            check({seen, cmd_code, cmd_bg, cmd_ba, cmd_die}, {1'b1, `CDD_CMD_ACT, 4'h6, 3'h0});
            check(cmd_addr, {i[0], 17'h16a5c});
            axi_wr(`CDD_REG_CTRL, 32'h9);
        end
        run(1, 1, 3'b101, 0, 0, 1);
        check(seen, 0);
        for (j = 0; j < 2; j++) for (i = 0; i < 8; i++) if (i != 3) begin
            run(0, 1, i[2:0], j ? 14'h1000 : 14'h0400, 0, 1);
            check(seen, i != 7);
            if (i != 7) check(cmd_code, exp_code(i[2:0], !j[0]));
            if (i == 4 || i == 5) check({cmd_auto_pre, cmd_chop, cmd_addr[13:0]}, {!j[0], !j[0], j ? 14'h1000 : 14'h0400});
            if (i == 0) check(mrs_select, 4'ha);
        end
        run(1, 1, 3'b111, 0, 0, 0);
        check(power_state, `CDD_PS_PPD);
        run(0, 1, 3'b101, 0, 0, 0);
        check(seen, 0);
        run(1, 1, 3'b111, 0, 0, 1);
        run(0, 0, 3'b000, 0, 0, 1);
        run(1, 1, 3'b111, 0, 0, 0);
        check(power_state, `CDD_PS_APD);
        run(0, 1, 3'b010, 14'h0400, 0, 1);
        run(0, 1, 3'b001, 0, 0, 0);
        check(power_state, `CDD_PS_SR);
        run(1, 1, 3'b111, 0, 0, 1);
        check(power_state, `CDD_PS_ACTIVE);
        axi_wr(`CDD_REG_CTRL, 32'h11);
        hm.set_die(3'h2);
        run(0, 1, 3'b100, 0, 0, 1);
        check(seen, 0);
        hm.set_die(3'h1);
        run(0, 1, 3'b100, 0, 0, 1);
        check({seen, cmd_die}, {1'b1, 3'h1});
        hm.set_die(3'h0);
        @(posedge aclk);
        {term_ctl, burst_done, thermal_event} <= 3'h7;
        axi_wr(`CDD_REG_CTRL, 32'h7);
        repeat (6) @(negedge aclk);
        check({nominal_termination_value, crc_append, vref_monitor, event_n}, 4'he);
        axi_wr(`CDD_REG_CTRL, 32'h0);
        repeat (6) @(negedge aclk);
        check({nominal_termination_value, crc_append, vref_monitor}, 3'h0);
        axi_rd(`CDD_REG_CTRL, d);
        check(d, 32'h0);
        @(posedge aclk);
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(`CDD_REG_CTRL, d);
        check(d, `CDD_CTRL_RESET);
        give_verdict;
    end
endmodule // ddr4_module_command_input_decode_tb
`default_nettype wire
